// File: hw/tsc_regs.svh
// register map, field positions, reset values and timing counts of the sensor core
// assumes a 10 MHz system clock; included by the design and the bench
`ifndef TSC_REGS_SVH
`define TSC_REGS_SVH

// index pointer values (2-bit register index)
`define TSC_IDX_TEMP     2'h0
`define TSC_IDX_CFG      2'h1
`define TSC_IDX_LOWER    2'h2
`define TSC_IDX_UPPER    2'h3

// configuration word field positions
`define TSC_B_FLAG       5
`define TSC_B_PER        6
`define TSC_B_SLEEP      8
`define TSC_B_LATCH      9
`define TSC_B_SENSE      10
`define TSC_B_FCNT       11
`define TSC_B_FIXED1     14
`define TSC_B_ONESHOT    15

// reset values
`define TSC_RST_PER      2'h2
`define TSC_RST_FCNT     2'h0
`define TSC_RST_UPPER    12'h500
`define TSC_RST_LOWER    12'h4b0
`define TSC_RST_TEMP     12'h000

// timing, times in ms and derived system clock counts
`define TSC_CLK_HZ       10000000
`define TSC_CYC_PER_MS   (`TSC_CLK_HZ / 1000)
`define TSC_PER0_MS      4000
`define TSC_PER1_MS      1000
`define TSC_PER2_MS      250
`define TSC_PER3_MS      125
`define TSC_SLPIN_MS     120
`define TSC_PER0_CYC     (`TSC_PER0_MS * `TSC_CYC_PER_MS)
`define TSC_PER1_CYC     (`TSC_PER1_MS * `TSC_CYC_PER_MS)
`define TSC_PER2_CYC     (`TSC_PER2_MS * `TSC_CYC_PER_MS)
`define TSC_PER3_CYC     (`TSC_PER3_MS * `TSC_CYC_PER_MS)
`define TSC_SLPIN_CYC    (`TSC_SLPIN_MS * `TSC_CYC_PER_MS)

`endif

// File: hw/tsc_pkg.sv
// types used by the sensor core; its bench does not import them
// holds no numbers; those live in tsc_regs.svh
package tsc_pkg;

  // power state of the conversion scheduler
  typedef enum {TSC_PM_RUN, TSC_PM_ENTER, TSC_PM_SLEEP} tsc_pm_e;

  // request carried across the link crossing
  typedef enum logic [1:0] {TSC_OP_RD, TSC_OP_WR, TSC_OP_GCALL} tsc_op_e;

endpackage

// File: hw/tsc_core.sv
// sensor core: configuration word, conversion scheduling, alert logic, link port
// assumes byte framing of the serial bus is done on lnk_clk by the caller
// Contract
// R01: config word 16 bits, MSB byte first
// R02: bits 0-4,13 read zero, bit 14 one
// R03: master keeps config bit 4 at zero
// R04: flag low after N high faults, back after N low
// R05: output sense sets flag active level
// R06: comparator mode: flag equals alert pin
// R07: period field 7:6 picks 4s/1s/250ms/125ms
// R08: temperature result changes only at conversion end
// R09: convert at power-on, standby between conversions
// R10: sleep enable stops conversions, entry takes 120ms
// R11: master pairs one-shot with sleep entry
// R12: registers stay accessible while sleeping
// R13: clearing sleep resumes periodic conversion
// R14: latch mode 0 comparator, 1 interrupt
// R15: comparator: alert from upper until below lower
// R16: interrupt: alert on each limit crossing
// R17: sense 0 active low, 1 active high
// R18: alert only after N consecutive faults
// R19: fault count field 12:11 gives 1..4
// R20: one-shot in sleep, reads 1 while converting
// R21: master limits repeated one-shot rate
// R22: interrupt alert clears on read or sleep
// R23: general call reset clears latch mode
// R24: 12-bit two's complement compares
// R25: upper fault on equal or above
// R26: alert logic evaluated at conversion end
`timescale 1ns/1ps
`include "tsc_regs.svh"

module tsc_core #(
  parameter logic [25:0] PER_4S_CYC   = 26'(`TSC_PER0_CYC),   // 4 s period
  parameter logic [25:0] PER_1S_CYC   = 26'(`TSC_PER1_CYC),   // 1 s period
  parameter logic [25:0] PER_250_CYC  = 26'(`TSC_PER2_CYC),   // 250 ms period
  parameter logic [25:0] PER_125_CYC  = 26'(`TSC_PER3_CYC),   // 125 ms period
  parameter logic [25:0] SLPIN_CYC    = 26'(`TSC_SLPIN_CYC)   // sleep entry time
) (
  input  wire logic        sys_clk,      // 10 MHz core clock
  input  wire logic        rst_n,        // async reset, active low
  input  wire logic        lnk_clk,      // link side clock
  input  wire logic        lnk_start,    // frame start, restarts byte pairing
  input  wire logic        lnk_idx_wr,   // pulse: lnk_byte loads index pointer
  input  wire logic        lnk_wr_byte,  // pulse: lnk_byte is a data byte
  input  wire logic        lnk_rd_byte,  // pulse: next read byte wanted
  input  wire logic        lnk_gcall,    // pulse: general call reset
  input  wire logic [7:0]  lnk_byte,     // byte from master
  output logic             lnk_busy,     // crossing in flight, requests ignored
  output logic             lnk_rd_valid, // pulse: lnk_rdata holds a byte
  output logic [7:0]       lnk_rdata,    // byte to master
  output logic             conv_start,   // pulse: start one conversion
  input  wire logic        conv_done,    // pulse: conversion finished
  input  wire logic [11:0] conv_result,  // converted temperature
  output logic             alert_pin,    // alert output level
  output logic             sleeping      // sleep fully entered
);
  import tsc_pkg::*;

  // ---------------- link domain ----------------
  logic [1:0]  idx_r;
  logic        phase_r;
  logic [7:0]  msb_r;
  logic        req_t_r;
  tsc_op_e     op_r;
  logic [1:0]  widx_r;
  logic [15:0] wdata_r;
  logic        pend_rd_r;
  logic        ack_s1_r;
  logic        ack_s2_r;
  logic        rd_valid_r;
  logic [7:0]  rdata_r;
  logic [15:0] rword_r;
  logic [15:0] rd_hold_r;
  logic        ack_r;         // written on sys_clk, read here only through ack_s1_r

  wire busy_l = req_t_r ^ ack_s2_r;
  wire fetched = pend_rd_r & ~busy_l;
  wire go_rd = lnk_rd_byte & ~busy_l & ~pend_rd_r;

  // ack synchroniser, second stage only is looked at
  always_ff @(posedge lnk_clk or negedge rst_n)
  begin
    if (!rst_n) begin ack_s1_r <= 1'b0; ack_s2_r <= 1'b0; end
    else begin ack_s1_r <= ack_r; ack_s2_r <= ack_s1_r; end
  end

  // byte pairing, MSB first; held operands stay put until ack returns
  always_ff @(posedge lnk_clk or negedge rst_n)
  begin
    if (!rst_n) begin
      idx_r <= `TSC_IDX_TEMP; phase_r <= 1'b0; msb_r <= 8'h00; req_t_r <= 1'b0;
      op_r <= TSC_OP_RD; widx_r <= 2'h0; wdata_r <= 16'h0000; pend_rd_r <= 1'b0;
      rd_valid_r <= 1'b0; rdata_r <= 8'h00; rword_r <= 16'h0000;
    end else begin
      rd_valid_r <= 1'b0;
      if (lnk_start && !busy_l) phase_r <= 1'b0;
      if (fetched)
      begin
        rword_r <= rd_hold_r;                 // stable: sys side waits for next request
        rdata_r <= rd_hold_r[15:8];           // [R01]
        rd_valid_r <= 1'b1;
        pend_rd_r <= 1'b0;
        phase_r <= 1'b1;
      end else if (!busy_l && !pend_rd_r) begin
        if (lnk_gcall)
        begin
          op_r <= TSC_OP_GCALL; req_t_r <= ~req_t_r;
        end else if (lnk_idx_wr) begin
          idx_r <= lnk_byte[1:0]; phase_r <= 1'b0;
        end else if (lnk_wr_byte && !phase_r) begin
          msb_r <= lnk_byte; phase_r <= 1'b1; // [R01]
        end else if (lnk_wr_byte) begin
          wdata_r <= {msb_r, lnk_byte}; widx_r <= idx_r;
          op_r <= TSC_OP_WR; req_t_r <= ~req_t_r; phase_r <= 1'b0;
        end else if (go_rd && !phase_r) begin
          widx_r <= idx_r; op_r <= TSC_OP_RD; req_t_r <= ~req_t_r; pend_rd_r <= 1'b1;
        end else if (lnk_rd_byte) begin
          rdata_r <= rword_r[7:0]; rd_valid_r <= 1'b1; phase_r <= 1'b0; // [R01]
        end
      end
    end
  end

  assign lnk_busy = busy_l | pend_rd_r;
  assign lnk_rd_valid = rd_valid_r;
  assign lnk_rdata = rdata_r;

  // ---------------- system domain ----------------
  logic        req_s1_r, req_s2_r, req_s3_r;
  logic [1:0]  per_sel_r, fcnt_sel_r;
  logic        sleep_r, latch_r, sense_r, oneshot_r;
  logic [11:0] upper_r, lower_r, temp_r;
  logic        tripped_r, irq_pend_r;
  logic [2:0]  fault_cnt_r;
  logic [25:0] per_cnt_r, slp_cnt_r;
  logic        conv_busy_r, conv_start_r;
  logic        os_run_r;      // the running conversion is the one-shot one
  tsc_pm_e     pm_r;

  // request synchroniser; the event compares the two later stages
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n) begin req_s1_r <= 1'b0; req_s2_r <= 1'b0; req_s3_r <= 1'b0; ack_r <= 1'b0; end
    else begin req_s1_r <= req_t_r; req_s2_r <= req_s1_r; req_s3_r <= req_s2_r; ack_r <= req_s3_r; end
  end

  // request decode
  wire req_ev  = req_s2_r ^ req_s3_r;
  wire wr_ev   = req_ev & (op_r == TSC_OP_WR);
  wire rd_ev   = req_ev & (op_r == TSC_OP_RD);
  wire gc_ev   = req_ev & (op_r == TSC_OP_GCALL);
  wire cfg_wr  = wr_ev & (widx_r == `TSC_IDX_CFG);
  wire w_sleep = wdata_r[`TSC_B_SLEEP];
  wire slp_in  = cfg_wr & w_sleep & ~sleep_r;
  wire os_req  = cfg_wr & wdata_r[`TSC_B_ONESHOT] & (sleep_r | w_sleep); // [R20]
  // a one-shot asked for during a running periodic conversion waits for it rather than being lost
  wire os_due  = oneshot_r & ~os_run_r & ~conv_busy_r;           // [R20]

  // alert flag and pin; both flip with sense so they agree in comparator mode
  wire alert_act  = latch_r ? irq_pend_r : tripped_r;            // [R14] [R15] [R16]
  wire flag_bit   = tripped_r ^ ~sense_r;                         // [R04] [R05]
  assign alert_pin = alert_act ^ ~sense_r;                        // [R17] [R06]

  // read view of the registers; unused bits fixed
  wire [15:0] cfg_word = {oneshot_r, 1'b1, 1'b0, fcnt_sel_r, sense_r, latch_r, sleep_r,
                          per_sel_r, flag_bit, 5'h00};            // [R02]
  wire [15:0] rd_word  = (widx_r == `TSC_IDX_TEMP)  ? {temp_r, 4'h0}  :
                         (widx_r == `TSC_IDX_CFG)   ? cfg_word        :
                         (widx_r == `TSC_IDX_LOWER) ? {lower_r, 4'h0} : {upper_r, 4'h0};

  // fault filtering on each finished conversion, signed compares
  wire hi_fault = $signed(conv_result) >= $signed(upper_r);      // [R24] [R25]
  wire lo_fault = $signed(conv_result) <  $signed(lower_r);      // [R24]
  wire fault    = tripped_r ? lo_fault : hi_fault;               // [R18]
  wire [2:0] need_n = {1'b0, fcnt_sel_r} + 3'd1;                 // [R19]
  wire reached  = conv_done & fault & (fault_cnt_r + 3'd1 >= need_n); // [R26]

  // period lookup
  wire [25:0] per_cyc = (per_sel_r == 2'h0) ? PER_4S_CYC :
                        (per_sel_r == 2'h1) ? PER_1S_CYC :
                        (per_sel_r == 2'h2) ? PER_250_CYC : PER_125_CYC; // [R07]
  wire start_cont = ~sleep_r & (per_cnt_r == 26'h0) & ~conv_busy_r; // [R09] [R10]
  wire start_now  = start_cont | os_due;

  // register writes; serial access never depends on power state
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n) begin
      per_sel_r <= `TSC_RST_PER; fcnt_sel_r <= `TSC_RST_FCNT; sleep_r <= 1'b0;
      latch_r <= 1'b0; sense_r <= 1'b0; upper_r <= `TSC_RST_UPPER;
      lower_r <= `TSC_RST_LOWER; rd_hold_r <= 16'h0000;
    end else begin
      if (rd_ev) rd_hold_r <= rd_word;                                   // [R12]
      if (cfg_wr)
      begin
        per_sel_r  <= wdata_r[`TSC_B_PER +: 2];                          // [R07]
        sleep_r    <= w_sleep;                                           // [R10] [R13]
        latch_r    <= wdata_r[`TSC_B_LATCH];
        sense_r    <= wdata_r[`TSC_B_SENSE];
        fcnt_sel_r <= wdata_r[`TSC_B_FCNT +: 2];
      end
      if (wr_ev && widx_r == `TSC_IDX_LOWER) lower_r <= wdata_r[15:4];
      if (wr_ev && widx_r == `TSC_IDX_UPPER) upper_r <= wdata_r[15:4];
      if (gc_ev) latch_r <= 1'b0;                                        // [R23]
    end
  end

  // result and alert state; a new event beats a same-cycle clear
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n) begin
      temp_r <= `TSC_RST_TEMP; tripped_r <= 1'b0; irq_pend_r <= 1'b0; fault_cnt_r <= 3'h0;
    end else begin
      if (conv_done) temp_r <= conv_result;                              // [R08]
      if (conv_done) fault_cnt_r <= (fault && !reached) ? fault_cnt_r + 3'd1 : 3'h0; // [R18]
      if (reached) tripped_r <= ~tripped_r;                              // [R04] [R15]
      if (reached && latch_r) irq_pend_r <= 1'b1;                        // [R16]
      else if (rd_ev || slp_in || gc_ev) irq_pend_r <= 1'b0;             // [R22]
    end
  end

  // scheduler: period countdown, conversion busy and one-shot flag
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n) begin
      per_cnt_r <= 26'h0; conv_busy_r <= 1'b0; conv_start_r <= 1'b0; oneshot_r <= 1'b0;
      os_run_r <= 1'b0;
    end else begin
      conv_start_r <= start_now;
      if (start_cont) per_cnt_r <= per_cyc - 26'd1;                      // [R07]
      else if (cfg_wr && !w_sleep && sleep_r) per_cnt_r <= 26'h0;        // [R13]
      else if (per_cnt_r != 26'h0 && !sleep_r) per_cnt_r <= per_cnt_r - 26'd1;
      if (start_now) conv_busy_r <= 1'b1;
      else if (conv_done) conv_busy_r <= 1'b0;
      if (os_req) oneshot_r <= 1'b1;                                     // [R20]
      else if (conv_done && os_run_r) oneshot_r <= 1'b0;
      if (os_due) os_run_r <= 1'b1;
      else if (conv_done) os_run_r <= 1'b0;
    end
  end

  // sleep entry needs its settle time before the core reports sleeping
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n) begin pm_r <= TSC_PM_RUN; slp_cnt_r <= 26'h0; end
    else begin
      unique case (pm_r)
        TSC_PM_RUN:   if (sleep_r) begin pm_r <= TSC_PM_ENTER; slp_cnt_r <= SLPIN_CYC; end
        TSC_PM_ENTER: if (!sleep_r) pm_r <= TSC_PM_RUN;
                      else if (slp_cnt_r <= 26'd1) pm_r <= TSC_PM_SLEEP;    // [R10]
                      else slp_cnt_r <= slp_cnt_r - 26'd1;
        TSC_PM_SLEEP: if (!sleep_r) pm_r <= TSC_PM_RUN;                  // [R13]
      endcase
    end
  end

  assign conv_start = conv_start_r;
  assign sleeping   = (pm_r == TSC_PM_SLEEP);

  // ---------------- assertions ----------------
  sequence s_cont_due;
    !sleep_r && per_cnt_r == 26'h0 && !conv_busy_r;
  endsequence
  sequence s_os_done;
    os_run_r && conv_done && !os_req;
  endsequence

  flag_follows_pin_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R06]
    !latch_r |-> (cfg_word[`TSC_B_FLAG] == alert_pin))
    else $error("flag differs from alert pin in comparator mode");
  fixed_bits_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R02]
    cfg_word[14:13] == 2'b10 && cfg_word[4:0] == 5'h00)
    else $error("unused config bits read wrong");
  temp_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R08]
    !conv_done |=> $stable(temp_r))
    else $error("temperature result changed without a conversion");
  period_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R09]
    s_cont_due |=> conv_start_r && per_cnt_r == $past(per_cyc) - 26'd1)
    else $error("scheduled conversion not started or period wrong");
  sleep_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R10]
    sleep_r && !os_due |=> !conv_start_r)
    else $error("conversion started while sleeping without one-shot");
  oneshot_end_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R20]
    s_os_done |=> !oneshot_r ##1 (!conv_start_r || !sleep_r))
    else $error("one-shot bit not cleared at conversion end");
  irq_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R22]
    rd_ev && !reached |=> !irq_pend_r)
    else $error("interrupt alert survived a register read");
  gcall_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R23]
    gc_ev |=> !latch_r)
    else $error("general call did not restore comparator mode");
  trip_cause_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R18]
    $rose(tripped_r) |-> $past(conv_done) && $past(hi_fault)
      && $past(fault_cnt_r) + 3'd1 >= $past(need_n))
    else $error("alert tripped without enough consecutive faults");
  sleep_entry_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R10]
    $rose(sleep_r) |-> !sleeping [*2])
    else $error("sleep reported before entry time");
  alert_eval_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R26]
    !conv_done |=> $stable(tripped_r) && $stable(fault_cnt_r))
    else $error("alert state changed without a finished conversion");

endmodule

// File: bench/tsc_link_master.sv
// link master model: index loads, word writes, word reads, general call
// assumes the core takes a request at posedge lnk_clk while lnk_busy is low
`timescale 1ns/1ps
module tsc_link_master (
  input  wire logic       lnk_clk,      // link clock
  input  wire logic       lnk_busy,     // crossing in flight
  input  wire logic       lnk_rd_valid, // read byte strobe
  input  wire logic [7:0] lnk_rdata,    // read byte
  output logic            lnk_start,    // frame start
  output logic            lnk_idx_wr,   // index load
  output logic            lnk_wr_byte,  // write byte
  output logic            lnk_rd_byte,  // read request
  output logic            lnk_gcall,    // general call
  output logic [7:0]      lnk_byte      // byte to core
);
  logic [4:0] req_r = 5'h00; // start, index, write, read, general call
  int         stuck = 0;     // waits that ran out
  initial lnk_byte = 8'h00;
  // one vector so a request is a single assignment
  assign {lnk_start, lnk_idx_wr, lnk_wr_byte, lnk_rd_byte, lnk_gcall} = req_r;

  // raise at a falling edge, hold over the taking edge, then release the byte line
  task automatic send(input logic [4:0] kind, input logic [7:0] b);
    @(negedge lnk_clk);
    for (int n = 0; n < 500 && lnk_busy !== 1'b0; n++) @(negedge lnk_clk);
    if (lnk_busy !== 1'b0) stuck++;
    req_r = kind;
    lnk_byte = b;
    @(negedge lnk_clk);
    req_r = 5'h00;
    lnk_byte = ~b; // released line must not keep the last value
  endtask

  // read byte taken at a falling edge while its strobe stands, settled since the rising edge
  task automatic get(output logic [7:0] b);
    for (int n = 0; n < 500 && lnk_rd_valid !== 1'b1; n++) @(negedge lnk_clk);
    if (lnk_rd_valid !== 1'b1) stuck++;
    b = lnk_rdata;
  endtask

  // index, then high byte and low byte; requests stay apart until busy drops
  task automatic wr(input logic [1:0] idx, input logic [15:0] v);
    send(5'h10, 8'h00);
    send(5'h08, {6'h00, idx});
    send(5'h04, v[15:8]);
    send(5'h04, v[7:0]);
    send(5'h00, 8'h00);
  endtask

  // index, then two read requests, high byte first
  task automatic rd(input logic [1:0] idx, output logic [15:0] v);
    send(5'h10, 8'h00);
    send(5'h08, {6'h00, idx});
    send(5'h02, 8'h00);
    get(v[15:8]);
    send(5'h02, 8'h00);
    get(v[7:0]);
  endtask
endmodule

// File: bench/tsc_core_tb.sv
// bench for the sensor core: link master model, converter stand-in, scenarios
// assumes the core is built with the short periods below
`timescale 1ns/1ps
`include "tsc_regs.svh"
module tsc_core_tb;
  localparam int PER [4] = '{400, 200, 100, 50};
  logic        sys_clk = 1'b0;
  logic        lnk_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        conv_done = 1'b0;
  logic [11:0] conv_result = 12'h000;
  logic [11:0] temp_val = 12'h100; // temperature the stand-in reports
  logic        lnk_start, lnk_idx_wr, lnk_wr_byte, lnk_rd_byte, lnk_gcall;
  logic [7:0]  lnk_byte, lnk_rdata;
  logic        lnk_busy, lnk_rd_valid, conv_start, alert_pin, sleeping;
  logic [15:0] v;
  int          num_errors = 0, tests_run = 0, conv_lat = 10, left = 0;
  int          cyc = 0, last = 0, gap = 0, n_start = 0, n_done = 0;

  // unrelated clocks: 100 ns core, 32 ns link with an odd offset
  always #50 sys_clk = ~sys_clk;
  initial #7 forever #16 lnk_clk = ~lnk_clk;

  tsc_core #(.PER_4S_CYC(26'(PER[0])), .PER_1S_CYC(26'(PER[1])), .PER_250_CYC(26'(PER[2])),
             .PER_125_CYC(26'(PER[3])), .SLPIN_CYC(26'd20)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .lnk_clk(lnk_clk), .lnk_start(lnk_start),
    .lnk_idx_wr(lnk_idx_wr), .lnk_wr_byte(lnk_wr_byte), .lnk_rd_byte(lnk_rd_byte),
    .lnk_gcall(lnk_gcall), .lnk_byte(lnk_byte), .lnk_busy(lnk_busy),
    .lnk_rd_valid(lnk_rd_valid), .lnk_rdata(lnk_rdata), .conv_start(conv_start),
    .conv_done(conv_done), .conv_result(conv_result), .alert_pin(alert_pin),
    .sleeping(sleeping));
  tsc_link_master i_master (
    .lnk_clk(lnk_clk), .lnk_busy(lnk_busy), .lnk_rd_valid(lnk_rd_valid),
    .lnk_rdata(lnk_rdata), .lnk_start(lnk_start), .lnk_idx_wr(lnk_idx_wr),
    .lnk_wr_byte(lnk_wr_byte), .lnk_rd_byte(lnk_rd_byte), .lnk_gcall(lnk_gcall),
    .lnk_byte(lnk_byte));

  // converter stand-in; result line toggles when not valid, start gaps are timed
  always @(negedge sys_clk)
  begin
    cyc++;
    conv_done <= 1'b0;
    conv_result <= ~conv_result;
    if (conv_start === 1'b1)
    begin
      gap = cyc - last;
      last = cyc;
      n_start++;
      left = conv_lat;
    end
    else if (left == 1)
    begin
      left = 0;
      conv_done <= 1'b1;
      conv_result <= temp_val;
      n_done++;
    end
    else if (left > 1) left--;
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // config word as written; bit 4 always left at zero
  function automatic logic [15:0] cw(input logic [1:0] per, input logic slp, input logic lat,
                                     input logic sns, input logic [1:0] fc, input logic ss);
    cw = {ss, 2'b10, fc, sns, lat, slp, per, 6'h00};
  endfunction

  // pin level: the sense bit is the active level
  function automatic logic al(input logic act, input logic sns);
    al = act ? sns : ~sns;
  endfunction

  // bounded wait for k conversions, then let the alert logic settle
  task automatic wait_conv(input int k);
    int m;
    repeat (k)
    begin
      m = n_done;
      for (int i = 0; i < 2000 && n_done == m; i++) @(negedge sys_clk);
      check("conversion done", 16'd1, 16'(n_done != m));
    end
    repeat (3) @(negedge sys_clk);
  endtask

  task automatic test_reset();
    repeat (3) @(negedge sys_clk);
    check("power-on start", 16'd1, 16'(n_start));
    check("alert idle", 16'd1, 16'(alert_pin));
    i_master.rd(`TSC_IDX_CFG, v);
    check("cfg reset", 16'h40a0, v);
    i_master.rd(`TSC_IDX_UPPER, v);
    check("upper reset", 16'h5000, v);
    i_master.rd(`TSC_IDX_LOWER, v);
    check("lower reset", 16'h4b00, v);
    temp_val = 12'he70;
    wait_conv(1);
    i_master.rd(`TSC_IDX_TEMP, v);
    check("temp result", 16'he700, v);
  endtask

  task automatic test_period();
    int m;
    for (int c = 0; c < 4; c++)
    begin
      i_master.wr(`TSC_IDX_CFG, cw(2'(c), 1'b0, 1'b0, 1'b0, 2'h0, 1'b0));
      m = n_start + 3;
      for (int i = 0; i < 5000 && n_start < m; i++) @(negedge sys_clk);
      check("period", 16'(PER[c]), 16'(gap));
    end
  endtask

  // every filter depth, both senses; equal-to-limit cases on both sides
  task automatic test_faults();
    for (int c = 0; c < 4; c++)
    begin
      temp_val = 12'h100;
      i_master.wr(`TSC_IDX_CFG, cw(2'h3, 1'b0, 1'b0, c[0], 2'(c), 1'b0));
      wait_conv(1);
      temp_val = 12'h500;
      wait_conv(c);
      check("alert early", 16'(al(1'b0, c[0])), 16'(alert_pin));
      wait_conv(1);
      check("alert set", 16'(al(1'b1, c[0])), 16'(alert_pin));
      i_master.rd(`TSC_IDX_CFG, v);
      check("cfg flag", cw(2'h3, 1'b0, 1'b0, c[0], 2'(c), 1'b0) | {10'h0, c[0], 5'h0}, v);
      temp_val = 12'h4b0;
      wait_conv(c + 1);
      check("alert hold", 16'(al(1'b1, c[0])), 16'(alert_pin));
      temp_val = 12'h4af;
      wait_conv(c + 1);
      check("alert clear", 16'(al(1'b0, c[0])), 16'(alert_pin));
    end
  endtask

  task automatic test_intr();
    temp_val = 12'h100;
    i_master.wr(`TSC_IDX_CFG, cw(2'h3, 1'b0, 1'b1, 1'b0, 2'h0, 1'b0));
    wait_conv(1);
    check("int idle", 16'd1, 16'(alert_pin));
    temp_val = 12'h600;
    wait_conv(2);
    check("int set", 16'd0, 16'(alert_pin));
    i_master.rd(`TSC_IDX_LOWER, v);
    repeat (3) @(negedge sys_clk);
    check("int read clear", 16'd1, 16'(alert_pin));
    temp_val = 12'h100;
    wait_conv(1);
    check("int low", 16'd0, 16'(alert_pin));
    i_master.send(5'h01, 8'h00);
    i_master.rd(`TSC_IDX_CFG, v);
    check("gcall mode", 16'd0, 16'(v[9]));
    check("gcall alert", 16'd1, 16'(alert_pin));
  endtask

  task automatic test_sleep();
    int m;
    conv_lat = 60;
    i_master.wr(`TSC_IDX_CFG, cw(2'h3, 1'b1, 1'b0, 1'b0, 2'h0, 1'b1));
    i_master.rd(`TSC_IDX_CFG, v);
    check("one-shot busy", 16'd1, 16'(v[15]));
    for (int i = 0; i < 400 && sleeping !== 1'b1; i++) @(negedge sys_clk);
    repeat (200) @(negedge sys_clk);
    check("asleep", 16'd1, 16'(sleeping));
    i_master.rd(`TSC_IDX_CFG, v);
    check("one-shot done", 16'd0, 16'(v[15]));
    m = n_start;
    i_master.wr(`TSC_IDX_CFG, cw(2'h3, 1'b1, 1'b0, 1'b0, 2'h0, 1'b1));
    wait_conv(1);
    check("one-shot again", 16'(m + 1), 16'(n_start));
    m = n_start;
    i_master.wr(`TSC_IDX_UPPER, 16'h7ff0);
    i_master.rd(`TSC_IDX_UPPER, v);
    check("upper asleep", 16'h7ff0, v);
    repeat (1000) @(negedge sys_clk);
    check("no starts asleep", 16'(m), 16'(n_start));
    conv_lat = 10;
    i_master.wr(`TSC_IDX_CFG, cw(2'h3, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0));
    wait_conv(3);
    check("awake gap", 16'd50, 16'(gap));
    check("awake", 16'd0, 16'(sleeping));
  endtask

  task automatic print_verdict();
    num_errors += i_master.stuck;
    $display("checks run %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // main sequence after 12 reset cycles
  initial
  begin
    repeat (12) @(negedge sys_clk);
    rst_n = 1'b1;
    test_reset();
    test_period();
    test_faults();
    test_intr();
    test_sleep();
    print_verdict();
  end

  // watchdog: the whole run needs well under 5 ms
  initial
  begin
    #5000000;
    num_errors++;
    print_verdict();
  end
endmodule
